// ===== oss_latch_bank.v
// One-second status page: four error counters latched once per second
// Assumes event inputs are one-cycle pulses from framer logic on clk,
// and a page-decoded read port (addr, rd_en) on the same clock.
//
// Operation
// - The latched registers sit at page offsets 10H to 16H and 17H to 1FH are unused.
// - The 10-bit E-bit count shows bits 9-8 in bits 1-0 at 10H and bits 7-0 at 11H.
// - Once a second the internal timer copies every running count into its latch.
// - An 8-bit counter counts errored frame alignment signals up to FFH and holds there, latched at 12H.
// - A 16-bit counter counts bipolar violations, high byte at 13H and low byte at 14H.
// - The 10-bit CRC-4 count shows bits 9-8 in bits 1-0 at 15H and bits 7-0 at 16H.
`timescale 1ns/1ps
`include "oss_defines.vh"
module oss_latch_bank #(
  parameter TICK_CYCLES = `OSS_TICK_CYCLES
) (
  input  wire       clk,
  input  wire       rstn,
  input  wire       ebit_error,
  input  wire       alignment_error,
  input  wire       bipolar_violation,
  input  wire       crc4_error,
  input  wire [4:0] addr,
  input  wire       rd_en,
  output reg  [7:0] rd_data,
  output reg        second_tick
);
  reg  [31:0]                 tick_count;
  wire [`OSS_EBIT_WIDTH-1:0]  latched_ebit_count;
  wire [`OSS_ALIGN_WIDTH-1:0] latched_alignment_error_count;
  wire [`OSS_BPV_WIDTH-1:0]   latched_violation_count;
  wire [`OSS_CRC_WIDTH-1:0]   latched_crc4_count;
  reg  [7:0]                  next_rd_data;
  wire                        tick_now = (tick_count == TICK_CYCLES - 1);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_count  <= 32'h00000000;
      second_tick <= 1'b0;
    end else begin
      tick_count  <= tick_now ? 32'h00000000 : tick_count + 32'h00000001;
      second_tick <= tick_now;
    end
  end

  oss_counter #(.WIDTH(`OSS_EBIT_WIDTH)) u_ebit (
    .clk         (clk),
    .rstn        (rstn),
    .event_pulse (ebit_error),
    .tick        (tick_now),
    .latched     (latched_ebit_count)
  );
  oss_counter #(.WIDTH(`OSS_ALIGN_WIDTH)) u_align (
    .clk         (clk),
    .rstn        (rstn),
    .event_pulse (alignment_error),
    .tick        (tick_now),
    .latched     (latched_alignment_error_count)
  );
  oss_counter #(.WIDTH(`OSS_BPV_WIDTH)) u_bpv (
    .clk         (clk),
    .rstn        (rstn),
    .event_pulse (bipolar_violation),
    .tick        (tick_now),
    .latched     (latched_violation_count)
  );
  oss_counter #(.WIDTH(`OSS_CRC_WIDTH)) u_crc (
    .clk         (clk),
    .rstn        (rstn),
    .event_pulse (crc4_error),
    .tick        (tick_now),
    .latched     (latched_crc4_count)
  );

  // Pure decode: reading never disturbs counters or latches
  always @* begin
    next_rd_data = `OSS_RESET_BYTE;
    case (addr)
      `OSS_OFS_EBIT_HIGH: next_rd_data = {6'h00, latched_ebit_count[9:8]};
      `OSS_OFS_EBIT_LOW:  next_rd_data = latched_ebit_count[7:0];
      `OSS_OFS_ALIGN:     next_rd_data = latched_alignment_error_count;
      `OSS_OFS_BPV_HIGH:  next_rd_data = latched_violation_count[15:8];
      `OSS_OFS_BPV_LOW:   next_rd_data = latched_violation_count[7:0];
      `OSS_OFS_CRC_HIGH:  next_rd_data = {6'h00, latched_crc4_count[9:8]};
      `OSS_OFS_CRC_LOW:   next_rd_data = latched_crc4_count[7:0];
      default:            next_rd_data = `OSS_RESET_BYTE;
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= `OSS_RESET_BYTE;
    end else if (rd_en) begin
      rd_data <= next_rd_data;
    end
  end
endmodule

// ===== oss_defines.vh
// Offsets, field positions, widths and timing for the one-second latch bank
// Included by the design files; holds definitions only
`ifndef OSS_DEFINES_VH
`define OSS_DEFINES_VH
`define OSS_OFS_EBIT_HIGH      5'h10
`define OSS_OFS_EBIT_LOW       5'h11
`define OSS_OFS_ALIGN          5'h12
`define OSS_OFS_BPV_HIGH       5'h13
`define OSS_OFS_BPV_LOW        5'h14
`define OSS_OFS_CRC_HIGH       5'h15
`define OSS_OFS_CRC_LOW        5'h16
`define OSS_EBIT_WIDTH         10
`define OSS_ALIGN_WIDTH        8
`define OSS_BPV_WIDTH          16
`define OSS_CRC_WIDTH          10
`define OSS_HIGH2_MSB          1
`define OSS_RESET_BYTE         8'h00
`define OSS_TICK_PERIOD_NS     1000000000
`define OSS_CLK_PERIOD_NS      5
`define OSS_TICK_CYCLES        (`OSS_TICK_PERIOD_NS / `OSS_CLK_PERIOD_NS)
`endif

// ===== oss_counter.v
// Saturating event counter with a latch copied on each one-second tick
// Events arrive as one-cycle pulses on the framer clock
`timescale 1ns/1ps
`include "oss_defines.vh"
module oss_counter #(
  parameter WIDTH = 8
) (
  input  wire             clk,
  input  wire             rstn,
  input  wire             event_pulse,
  input  wire             tick,
  output reg  [WIDTH-1:0] latched
);
  reg  [WIDTH-1:0] running;
  wire             full = &running;
  wire [WIDTH-1:0] bumped = (event_pulse && !full) ? running + 1'b1 : running;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      running <= {WIDTH{1'b0}};
      latched <= {WIDTH{1'b0}};
    end else if (tick) begin
      // Event on the tick edge opens the new interval, not lost
      latched <= running;
      running <= event_pulse ? {{(WIDTH-1){1'b0}}, 1'b1} : {WIDTH{1'b0}};
    end else begin
      running <= bumped;
    end
  end
endmodule

// ===== oss_latch_bank_checker.sv
// Read port and tick assertions for the one-second latch bank
// Bound to oss_latch_bank; sees only its ports
`timescale 1ns/1ps
`include "oss_defines.vh"
module oss_latch_bank_checker #(
  parameter TICK_CYCLES = `OSS_TICK_CYCLES
) (
  input wire       clk, rstn, ebit_error, alignment_error,
  input wire       bipolar_violation, crc4_error, rd_en, second_tick,
  input wire [4:0] addr,
  input wire [7:0] rd_data
);
  int cnt;
  always @(posedge clk or negedge rstn)
    if (!rstn) cnt <= 0;
    else cnt <= second_tick ? 1 : cnt + 1;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_low_zero:
    assert property (rd_en && addr < 5'h10 |=> rd_data == 8'h00) else $error("low read");
  a_high_zero:
    assert property (rd_en && addr > 5'h16 |=> rd_data == 8'h00) else $error("high read");
  a_ebit_top:
    assert property (rd_en && addr == 5'h10 |=> rd_data[7:2] == 6'h00) else $error("ebit top");
  a_crc_top:
    assert property (rd_en && addr == 5'h15 |=> rd_data[7:2] == 6'h00) else $error("crc top");
  a_tick_period:
    assert property (second_tick == (cnt == TICK_CYCLES)) else $error("tick period");
  a_idle_stable:
    assert property (!rd_en |=> $stable(rd_data)) else $error("idle change");
  a_latch_hold:
    assert property (rd_en && $past(rd_en) && addr == $past(addr) && !second_tick
      |=> rd_data == $past(rd_data)) else $error("latch moved");
endmodule

// ===== oss_latch_bank_test.sv
// Bench for the one-second latch bank: layout, counts, tick, hold
// Inputs change at the falling edge; tick period shortened
`timescale 1ns/1ps
module oss_latch_bank_test;
  localparam TICK_CYCLES = 600;
  logic clk = 0, rstn = 0, ebit_error = 0, alignment_error = 0;
  logic bipolar_violation = 0, crc4_error = 0, rd_en = 0, second_tick;
  logic [4:0] addr = 5'h00;
  logic [7:0] rd_data;
  int bad_count = 0, num_checks = 0, i;
  logic [15:0] rows [10] = '{16'h1001, 16'h112C, 16'h12FF, 16'h1301, 16'h142C,
                             16'h1501, 16'h1604, 16'h1700, 16'h1F00, 16'h0F00};
  oss_latch_bank #(.TICK_CYCLES(TICK_CYCLES)) oss_latch_bank_inst (.*);
  task results;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task rd(input logic [4:0] a, input logic [7:0] e);
    addr = a;
    rd_en = 1;
    @(negedge clk);
    num_checks++;
    if (rd_data !== e) begin
      $display("mismatch %0t read %h got %h", $time, a, rd_data);
      bad_count++;
    end
  endtask
  // Bounded wait for the tick pulse
  task wt;
    for (i = 0; i < 700 && second_tick !== 1'b1; i++) @(negedge clk);
    if (i == 700) begin
      $display("mismatch %0t no second tick", $time);
      bad_count++;
      results;
    end
  endtask
  initial begin
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (16) @(negedge clk);
    rstn = 1;
    rd(5'h11, 8'h00);
    {ebit_error, alignment_error, bipolar_violation} = 3'h7;
    // 300 events overflow the 8-bit alignment count
    for (i = 0; i < 300; i++) begin
      crc4_error = i < 260;
      @(negedge clk);
    end
    {ebit_error, alignment_error, bipolar_violation, crc4_error} = 4'h0;
    wt;
    foreach (rows[k]) rd(rows[k][12:8], rows[k][7:0]);
    $display("layout test done");
    wt;
    rd(5'h11, 8'h00);
    rd(5'h11, 8'h00);
    rd_en = 0;
    $display("interval test done");
    results;
  end
endmodule
bind oss_latch_bank oss_latch_bank_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_inst (.*);
